// *** design/adc_serial_ready_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_serial_ready_sync
  import adc_port_pkg::*;
#(
  parameter int WIDTH = adc_port_pkg::DATA_BITS,
  parameter int DEPTH = adc_port_pkg::FIFO_DEPTH,
  parameter int NREGS = adc_port_pkg::NUM_CTRL_REGS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_din,
  input wire logic i_sync_n,
  input wire logic [WIDTH-1:0] i_conv_data,
  input wire logic i_conv_valid,
  output logic o_conv_ready,
  output logic o_dout_rdy_n,
  output logic o_filter_reset,
  output logic o_mod_reset,
  output logic [NREGS-1:1][WIDTH-1:0] o_ctrl_regs
);
  import adc_port_pkg::*;

  localparam logic [4:0] CMD_LAST = 5'(CMD_BITS - 1);
  localparam logic [4:0] DATA_LAST = 5'(WIDTH - 1);
  localparam logic [3:0] BLANK_LOAD = 4'(RDY_BLANK_CYC);

  stream_if #(.WIDTH(WIDTH)) wr_bus();
  stream_if #(.WIDTH(WIDTH)) rd_bus();

  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic sclk_prev;
  serial_state_type state;
  logic [4:0] bit_cnt;
  logic [WIDTH-1:0] rx_shift;
  logic [WIDTH-1:0] tx_shift;
  logic read_mode;
  logic [ADDR_BITS-1:0] addr;
  logic rdy_n;
  logic [3:0] blank_cnt;

  wire cs_active = !pin_sync[PIN_CS];
  wire sclk_rise = pin_sync[PIN_SCLK] && !sclk_prev;
  wire sclk_fall = !pin_sync[PIN_SCLK] && sclk_prev;
  wire sync_low = !pin_sync[PIN_SYNC];
  wire [WIDTH-1:0] next_rx = {rx_shift[WIDTH-2:0], pin_sync[PIN_DIN]};
  wire [ADDR_BITS-1:0] cmd_addr = next_rx[CMD_ADDR_LSB +: ADDR_BITS];
  wire cmd_read = next_rx[CMD_READ_BIT];
  wire cmd_done = cs_active && sclk_rise && (state == ST_CMD) && (bit_cnt == CMD_LAST);
  wire data_done = cs_active && sclk_rise && (state == ST_DATA) && (bit_cnt == DATA_LAST);
  wire addr_is_ctrl = (cmd_addr != ADDR_DATA) && (32'(cmd_addr) < NREGS);
  wire wr_is_ctrl = (addr != ADDR_DATA) && (32'(addr) < NREGS);
  wire [WIDTH-1:0] ctrl_word = addr_is_ctrl ? o_ctrl_regs[cmd_addr] : '0;
  wire [WIDTH-1:0] read_word = (cmd_addr == ADDR_DATA) ? rd_bus.data : ctrl_word;
  wire read_phase = cs_active && (state == ST_DATA) && read_mode;
  wire result_push = wr_bus.valid && wr_bus.ready;
  wire next_rdy_n = sync_low || (blank_cnt != 4'h0) || !rd_bus.valid;

  assign wr_bus.data = i_conv_data;
  assign wr_bus.valid = i_conv_valid && !sync_low;
  assign o_conv_ready = wr_bus.ready;
  assign rd_bus.ready = cmd_done && cmd_read && (cmd_addr == ADDR_DATA);

  result_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_flush(sync_low),
    .wr(wr_bus),
    .rd(rd_bus)
  );

  // two-stage pin synchronisers; sclk edges come from the second stage
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pin_meta <= PIN_RESET;
      pin_sync <= PIN_RESET;
      sclk_prev <= 1'b1;
    end else begin
      pin_meta <= {i_sync_n, i_din, i_sclk, i_cs_n};
      pin_sync <= pin_meta;
      sclk_prev <= pin_sync[PIN_SCLK];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_filter_reset <= 1'b1;
      o_mod_reset <= 1'b1;
    end else begin
      o_filter_reset <= sync_low;
      o_mod_reset <= sync_low;
    end
  end

  // short blanking of ready when a new result lands on an unread one
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      blank_cnt <= 4'h0;
      rdy_n <= 1'b1;
    end else begin
      if (result_push && rd_bus.valid) begin
        blank_cnt <= BLANK_LOAD;
      end else if (blank_cnt != 4'h0) begin
        blank_cnt <= blank_cnt - 4'h1;
      end
      rdy_n <= next_rdy_n;
    end
  end

  // framing runs from select and sclk only, never from sync
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !cs_active) begin
      state <= ST_CMD;
      bit_cnt <= 5'h00;
      read_mode <= 1'b0;
    end else if (sclk_rise) begin
      unique case (state)
        ST_CMD: begin
          if (bit_cnt == CMD_LAST) begin
            state <= ST_DATA;
            bit_cnt <= 5'h00;
            read_mode <= cmd_read;
          end else begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        ST_DATA: begin
          if (bit_cnt == DATA_LAST) begin
            state <= ST_CMD;
            bit_cnt <= 5'h00;
          end else begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rx_shift <= '0;
      addr <= '0;
    end else if (cs_active && sclk_rise) begin
      rx_shift <= next_rx;
      if (cmd_done) begin
        addr <= cmd_addr;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_ctrl_regs <= {(NREGS - 1){CTRL_RESET}};
    end else if (data_done && !read_mode && wr_is_ctrl) begin
      o_ctrl_regs[addr] <= next_rx;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tx_shift <= '0;
    end else if (cmd_done) begin
      tx_shift <= read_word;
    end else if (read_phase && sclk_fall) begin
      tx_shift <= {tx_shift[WIDTH-2:0], 1'b0};
    end
  end

  // pin shows read data during a read phase, ready otherwise
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_dout_rdy_n <= 1'b1;
    end else if (read_phase) begin
      if (sclk_fall) begin
        o_dout_rdy_n <= tx_shift[WIDTH-1];
      end
    end else begin
      o_dout_rdy_n <= rdy_n;
    end
  end
endmodule
`default_nettype wire

// *** pkg/adc_port_pkg.sv ***
package adc_port_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CMD_BITS = 8;
  localparam int DATA_BITS = 24;
  localparam int ADDR_BITS = 6;
  localparam int CMD_READ_BIT = 6;
  localparam int CMD_ADDR_LSB = 0;
  localparam logic [5:0] ADDR_DATA = 6'h00;
  localparam int NUM_CTRL_REGS = 4;
  localparam logic [23:0] CTRL_RESET = 24'h000000;
  localparam int FIFO_DEPTH = 32;
  localparam int RDY_BLANK_NS = 100;
  localparam int RDY_BLANK_CYC = (RDY_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_DIN = 2;
  localparam int PIN_SYNC = 3;
  localparam logic [3:0] PIN_RESET = 4'hB;

  typedef enum logic [1:0] {
    ST_CMD = 2'b01,
    ST_DATA = 2'b10
  } serial_state_type;
endpackage

// *** pkg/stream_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface stream_if #(parameter int WIDTH = 24);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface
`default_nettype wire

// *** design/result_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
module result_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_flush,
  stream_if.snk wr,
  stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic has_room;

  wire push = wr.valid && has_room;
  wire pop = rd.ready && rd.valid;
  wire [AW:0] next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);

  // room flag kept as its own register so ready leaves a flip-flop directly
  assign wr.ready = has_room;

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= wr.data;
    end
    rd.data <= mem[rd_ptr];
  end

  // read data lags pointer by a cycle, so valid drops for one cycle after a pop
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || i_flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      has_room <= 1'b1;
      rd.valid <= 1'b0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= next_count;
      has_room <= (next_count != DEPTH_CNT);
      rd.valid <= (count != '0) && !pop;
    end
  end
endmodule
`default_nettype wire

// *** tb/host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic i_sys_clk,
  input wire logic i_dout_rdy_n,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_din = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge i_sys_clk);
  endtask
  // command byte then 24 data bits, msb first; clock stands high between frames
  task automatic xfer(input logic [31:0] tx, output logic [23:0] rx);
    o_cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      half();
      o_sclk = 1'b0;
      o_din = tx[i];
      half();
      o_sclk = 1'b1;
      rx = {rx[22:0], i_dout_rdy_n};
    end
    half();
    o_cs_n = 1'b1;
    o_din = ~o_din;
    half();
  endtask
endmodule
`default_nettype wire

// *** tb/adc_serial_ready_sync_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_serial_ready_sync_sva #(
  parameter int WIDTH = 24,
  parameter int NREGS = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sync_n,
  input wire logic i_conv_valid,
  input wire logic o_conv_ready,
  input wire logic o_dout_rdy_n,
  input wire logic o_filter_reset,
  input wire logic o_mod_reset,
  input wire logic [NREGS-1:1][WIDTH-1:0] o_ctrl_regs
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  filt_hold_a: assert property (!i_sync_n [*3] |=> o_filter_reset)
    else $error("filter reset not held");
  filt_free_a: assert property (i_sync_n [*3] |=> !o_filter_reset)
    else $error("filter reset not released");
  mod_hold_a: assert property (!i_sync_n [*3] |=> o_mod_reset)
    else $error("modulator reset not held");
  mod_free_a: assert property (i_sync_n [*3] |=> !o_mod_reset)
    else $error("modulator reset not released");
  sync_ready_a: assert property ((!i_sync_n && i_cs_n) [*6] |=> o_dout_rdy_n)
    else $error("ready not forced high");
  push_ready_a: assert property (i_sync_n [*3] ##0 (i_conv_valid && o_conv_ready && i_cs_n)
    ##1 (!i_conv_valid && i_cs_n && i_sync_n) [*8] |=> !o_dout_rdy_n)
    else $error("ready did not fall");
  blank_ready_a: assert property (!o_dout_rdy_n && i_cs_n && i_conv_valid && o_conv_ready
    |-> ##[1:6] o_dout_rdy_n)
    else $error("ready not blanked");
  idle_regs_a: assert property (i_cs_n [*8] |=> $stable(o_ctrl_regs))
    else $error("control register changed idle");
endmodule
`default_nettype wire

// *** tb/test_adc_serial_ready_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_adc_serial_ready_sync;
  import adc_port_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_sync_n = 1'b1;
  logic i_conv_valid = 1'b0;
  logic [23:0] i_conv_data = 24'h000000;
  wire logic cs_n, sclk, din, rdy_n, conv_ready, filt_rst, mod_rst;
  wire logic [3:1][23:0] regs;
  int fail_count = 0;
  int comparisons = 0;
  int seed = 32'hb8f2;
  logic [23:0] got;
  logic [23:0] w [1:3];
  logic [23:0] q [$];
  always #(CLK_PERIOD_NS / 2) i_sys_clk = ~i_sys_clk;
  adc_serial_ready_sync adc_serial_ready_sync_i (.i_sys_clk, .i_rst, .i_cs_n(cs_n),
    .i_sclk(sclk), .i_din(din), .i_sync_n, .i_conv_data, .i_conv_valid,
    .o_conv_ready(conv_ready), .o_dout_rdy_n(rdy_n), .o_filter_reset(filt_rst),
    .o_mod_reset(mod_rst), .o_ctrl_regs(regs));
  host_model host_model_i (.i_sys_clk, .i_dout_rdy_n(rdy_n), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_din(din));
  task automatic chk_word(input string n, input logic [23:0] e, input logic [23:0] a);
    comparisons++;
    if (a !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, a);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic a);
    chk_word(n, {23'h000000, e}, {23'h000000, a});
  endtask
  task automatic push(input logic [23:0] d);
    i_conv_data = d;
    i_conv_valid = 1'b1;
    while (conv_ready !== 1'b1) @(negedge i_sys_clk);
    @(negedge i_sys_clk);
    q.push_back(d);
  endtask
  task automatic wait_rdy(input logic e);
    for (int n = 0; n < 20 && rdy_n !== e; n++) @(negedge i_sys_clk);
    chk_bit("ready pin", e, rdy_n);
  endtask
  task automatic sync_set(input logic v);
    i_sync_n = v;
    repeat (6) @(negedge i_sys_clk);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #500000;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (3) @(negedge i_sys_clk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_sys_clk);
    for (int k = 1; k < 4; k++) begin
      if (k == 3) sync_set(1'b0);
      w[k] = 24'($random(seed));
      host_model_i.xfer({2'b00, 6'(k), w[k]}, got);
      chk_word("ctrl reg", w[k], regs[k]);
    end
    push(24'($random(seed)));
    i_conv_valid = 1'b0;
    q.delete();
    repeat (12) @(negedge i_sys_clk);
    chk_bit("filter reset", 1'b1, filt_rst);
    chk_bit("mod reset", 1'b1, mod_rst);
    chk_bit("ready pin", 1'b1, rdy_n);
    for (int k = 1; k < 4; k++) begin
      host_model_i.xfer({2'b01, 6'(k), 24'h000000}, got);
      chk_word("ctrl readback", w[k], got);
    end
    host_model_i.xfer({2'b01, 6'h05, 24'h000000}, got);
    chk_word("unmapped read", 24'h000000, got);
    sync_set(1'b1);
    chk_bit("filter reset", 1'b0, filt_rst);
    push(24'($random(seed)));
    i_conv_valid = 1'b0;
    wait_rdy(1'b0);
    push(24'($random(seed)));
    i_conv_valid = 1'b0;
    wait_rdy(1'b1);
    wait_rdy(1'b0);
    for (int n = 0; n < 30; n++) push(24'($random(seed)));
    i_conv_valid = 1'b0;
    chk_bit("fifo space", 1'b0, conv_ready);
    wait_rdy(1'b0);
    while (q.size() > 0) begin
      host_model_i.xfer({2'b01, ADDR_DATA, 24'h000000}, got);
      chk_word("result", q.pop_front(), got);
    end
    wait_rdy(1'b1);
    push(24'($random(seed)));
    i_conv_valid = 1'b0;
    wait_rdy(1'b0);
    sync_set(1'b0);
    chk_bit("ready pin", 1'b1, rdy_n);
    end_of_test();
  end
endmodule
bind adc_serial_ready_sync adc_serial_ready_sync_sva #(.WIDTH(WIDTH), .NREGS(NREGS)) sva_i (
  .i_sys_clk, .i_rst, .i_cs_n, .i_sync_n, .i_conv_valid, .o_conv_ready, .o_dout_rdy_n,
  .o_filter_reset, .o_mod_reset, .o_ctrl_regs);
`default_nettype wire
